/* File: rtl/buck_boost_modulation_control.sv */
// Functional notes
// (R1) Boost peak overcurrent lowers boost duty cycle.
// (R2) Normal mode: buck runs fixed-frequency PWM at 450 kHz.
// (R3) Entering Stop switches buck to PFM; PFM is Stop default.
// (R4) Boost running in Stop stays PWM only.
// (R5) Stop, auto upshift on: overcurrent gives PWM, interrupt event, status flag.
// (R6) Software writes Stop command again to return to PFM after upshift.
// (R7) Auto upshift blocked after Stop entry: 1 ms if lag bit 1, else 100 us.
// (R8) Lag applies on every PWM to PFM change.
// (R9) Auto upshift enable 0: no load-driven PFM to PWM change.
// (R10) Pin mode bit 1: wake pin low PFM, high PWM in Stop.
// (R11) Pin mode acts on the raw wake level, no filter.
// (R12) Pin mode bit 0: wake pin ignored, Stop uses PFM.
// (R13) Stop to Normal command switches buck to PWM.
// (R14) Boost running at Stop to Normal keeps running unchanged.
// (R15) Sleep and Fail-Safe: buck and boost both off.
// (R16) Wake in Sleep/Fail-Safe enters Restart, then Normal after reset release.
// (R17) Restart ramps buck and re-enables boost per Normal settings on low supply.
// (R18) Reset output held until buck output exceeds reset threshold.
// (R19) Boost enabled: on below supply threshold, off above threshold plus hysteresis.
// (R20) Auto upshift flag stays set until software clears it.
module buck_boost_modulation_control (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	// Avalon-MM slave
	input wire logic [3:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	output logic [1:0] avs_response_o,
	// Analog comparator and event inputs
	input wire logic wake_pin_i,
	input wire logic bus_wake_i,
	input wire logic load_over_thr_i,
	input wire logic supply_below_thr_i,
	input wire logic supply_above_hys_i,
	input wire logic boost_peak_oc_i,
	input wire logic buck_above_rst_thr_i,
	// Regulator controls
	output logic buck_en_o,
	output logic buck_pwm_o,
	output logic buck_tick_o,
	output logic boost_on_o,
	output logic boost_duty_down_o,
	output logic int_event_o,
	output logic reset_output_pin_n_o
);
	import modctl_pkg::*;

	typedef enum logic [1:0] {MOD_OFF, MOD_PWM, MOD_PFM_LAG, MOD_PFM} mod_t;

	op_mode_t mode_r, mode_nxt;
	mod_t mod_r, mod_nxt;
	logic [31:0] hardware_control_register_r, hardware_control_register_nxt;
	logic flag_r, flag_nxt;
	logic auto_up_r, auto_up_nxt;
	logic boost_r, boost_nxt;
	logic duty_dn_r, duty_dn_nxt;
	logic int_r, int_nxt;
	logic rst_out_n_r, rst_out_n_nxt;
	logic pwm_r, pwm_nxt;
	logic en_r, en_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic ack_r, ack_nxt;
	logic wait_r;
	logic [1:0] resp_r, resp_nxt;
	logic tick;
	logic wr_stop, wr_mode, clr_flag, up_event, mapped;

	modctl_if lag_bus ();

	lag_timer u_lag (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.tmr(lag_bus)
	);

	pwm_tick u_tick (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.run_i(pwm_r),
		.tick_o(tick)
	);

	// Bus decode; one wait cycle, answer on the cycle after the request
	always_comb begin
		mapped = (avs_address_i == MODE_CTRL_OFS) || (avs_address_i == HARDWARE_CONTROL_REGISTER_OFS) ||
			(avs_address_i == WAKE_STAT_OFS) || (avs_address_i == REG_STATE_OFS);
		wr_mode = avs_write_i && !ack_r && avs_address_i == MODE_CTRL_OFS && avs_byteenable_i[0];
		wr_stop = wr_mode && avs_writedata_i[2:0] == OP_STOP;
		clr_flag = avs_write_i && !ack_r && avs_address_i == WAKE_STAT_OFS &&
			avs_byteenable_i[0] && avs_writedata_i[AUTO_UP_FLAG_BIT];
		ack_nxt = (avs_read_i || avs_write_i) && !ack_r;
		resp_nxt = mapped ? 2'h0 : 2'h2;
		rdata_nxt = 32'h0000_0000;
		if (avs_read_i && !ack_r) begin
			unique case (avs_address_i)
				MODE_CTRL_OFS: rdata_nxt = {29'h0, mode_r};
				HARDWARE_CONTROL_REGISTER_OFS: rdata_nxt = hardware_control_register_r;
				WAKE_STAT_OFS: rdata_nxt = {31'h0, flag_r};
				REG_STATE_OFS: rdata_nxt = {26'h0, rst_out_n_r, duty_dn_r, boost_r,
					auto_up_r, pwm_r, en_r};
				default: rdata_nxt = 32'h0000_0000;
			endcase
		end
	end

	// Hardware control register with byte enable on the low byte
	always_comb begin
		hardware_control_register_nxt = hardware_control_register_r;
		if (avs_write_i && !ack_r && avs_address_i == HARDWARE_CONTROL_REGISTER_OFS && avs_byteenable_i[0]) begin
			hardware_control_register_nxt = {28'h0, avs_writedata_i[3:0]};
		end
	end

	// Operating mode sequencing
	always_comb begin
		mode_nxt = mode_r;
		unique case (mode_r)
			OP_SLEEP, OP_FAILSAFE: begin
				if (wake_pin_i || bus_wake_i) mode_nxt = OP_RESTART; // see (R16)
			end
			OP_RESTART: begin
				if (rst_out_n_r) mode_nxt = OP_NORMAL; // see (R16)
			end
			default: begin
				if (wr_mode && avs_writedata_i[2:0] <= 3'h3) begin
					mode_nxt = op_mode_t'(avs_writedata_i[2:0]); // see (R13)
				end
			end
		endcase
	end

	// Buck modulation; lag restarts on every change into PFM
	always_comb begin
		mod_nxt = mod_r;
		lag_bus.start = 1'b0;
		lag_bus.long_sel = hardware_control_register_r[LAG_SEL_BIT];
		up_event = 1'b0;
		auto_up_nxt = auto_up_r;
		if (mode_nxt == OP_SLEEP || mode_nxt == OP_FAILSAFE) begin
			mod_nxt = MOD_OFF; // see (R15)
			auto_up_nxt = 1'b0;
		end else if (mode_nxt != OP_STOP) begin
			mod_nxt = MOD_PWM; // see (R2) (R13) (R17)
			auto_up_nxt = 1'b0;
		end else if (wr_stop || mode_r != OP_STOP) begin
			// Fresh Stop command returns to PFM and clears upshift lock
			mod_nxt = MOD_PFM_LAG; // see (R3) (R6)
			lag_bus.start = 1'b1; // see (R7) (R8)
			auto_up_nxt = 1'b0;
		end else if (hardware_control_register_r[PIN_MOD_EN_BIT]) begin
			// Raw pin level, deliberately unfiltered
			if (wake_pin_i && mod_r != MOD_PWM) begin
				mod_nxt = MOD_PWM; // see (R10) (R11)
			end else if (!wake_pin_i && mod_r == MOD_PWM && !auto_up_r) begin
				mod_nxt = MOD_PFM_LAG; // see (R10) (R8)
				lag_bus.start = 1'b1;
			end
		end else if (mod_r == MOD_PWM && !auto_up_r) begin
			mod_nxt = MOD_PFM_LAG; // see (R12) (R8)
			lag_bus.start = 1'b1;
		end
		if (mod_nxt != MOD_OFF && mod_r == MOD_PFM_LAG && lag_bus.done) mod_nxt = MOD_PFM;
		// Upshift only after lag and only when enabled
		if (mode_r == OP_STOP && !lag_bus.start && mod_r == MOD_PFM &&
			mod_nxt == MOD_PFM && hardware_control_register_r[AUTO_UP_EN_BIT] && load_over_thr_i) begin
			mod_nxt = MOD_PWM; // see (R5) (R9)
			up_event = 1'b1;
			auto_up_nxt = 1'b1;
		end
		pwm_nxt = (mod_nxt == MOD_PWM);
		en_nxt = (mod_nxt != MOD_OFF);
		int_nxt = up_event; // see (R5)
		// Set wins over a same-cycle software clear
		flag_nxt = up_event ? 1'b1 : (clr_flag ? 1'b0 : flag_r); // see (R20)
	end

	// Boost hysteresis control; PWM only, so no modulation choice here
	always_comb begin
		boost_nxt = boost_r;
		if (mode_nxt == OP_SLEEP || mode_nxt == OP_FAILSAFE ||
			!hardware_control_register_r[BOOST_EN_BIT]) begin
			boost_nxt = 1'b0; // see (R15)
		end else if (supply_below_thr_i) begin
			boost_nxt = 1'b1; // see (R19) (R17)
		end else if (supply_above_hys_i) begin
			boost_nxt = 1'b0; // see (R19)
		end
		// Mode changes other than into Sleep or Fail-Safe never touch a running boost, see (R4) (R14)
		duty_dn_nxt = boost_nxt && boost_peak_oc_i; // see (R1)
		// Reset output follows buck voltage only while buck runs
		rst_out_n_nxt = en_nxt && buck_above_rst_thr_i; // see (R18)
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mode_r <= OP_RESTART;
			mod_r <= MOD_PWM;
			hardware_control_register_r <= HARDWARE_CONTROL_REGISTER_RST;
			flag_r <= 1'b0;
			auto_up_r <= 1'b0;
			boost_r <= 1'b0;
			duty_dn_r <= 1'b0;
			int_r <= 1'b0;
			rst_out_n_r <= 1'b0;
			pwm_r <= 1'b1;
			en_r <= 1'b1;
			rdata_r <= 32'h0000_0000;
			ack_r <= 1'b0;
			resp_r <= 2'h0;
		end else begin
			mode_r <= mode_nxt;
			mod_r <= mod_nxt;
			hardware_control_register_r <= hardware_control_register_nxt;
			flag_r <= flag_nxt;
			auto_up_r <= auto_up_nxt;
			boost_r <= boost_nxt;
			duty_dn_r <= duty_dn_nxt;
			int_r <= int_nxt;
			rst_out_n_r <= rst_out_n_nxt;
			pwm_r <= pwm_nxt;
			en_r <= en_nxt;
			rdata_r <= rdata_nxt;
			ack_r <= ack_nxt;
			resp_r <= resp_nxt;
		end
	end

	// Waitrequest kept in its own flop so the pin never sees an inverter
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) wait_r <= 1'b1;
		else wait_r <= !ack_nxt;
	end

	// Tick register keeps every output flop-driven
	logic tick_r;
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) tick_r <= 1'b0;
		else tick_r <= tick; // see (R2)
	end

	assign buck_en_o = en_r;
	assign buck_pwm_o = pwm_r;
	assign buck_tick_o = tick_r;
	assign boost_on_o = boost_r;
	assign boost_duty_down_o = duty_dn_r;
	assign int_event_o = int_r;
	assign reset_output_pin_n_o = rst_out_n_r;
	assign avs_readdata_o = rdata_r;
	assign avs_waitrequest_o = wait_r;
	assign avs_response_o = resp_r;
endmodule

/* File: pkg/modctl_pkg.sv */
package modctl_pkg;
	// Register byte offsets (each register one aligned word)
	localparam logic [3:0] MODE_CTRL_OFS = 4'h0;
	localparam logic [3:0] HARDWARE_CONTROL_REGISTER_OFS = 4'h4;
	localparam logic [3:0] WAKE_STAT_OFS = 4'h8;
	localparam logic [3:0] REG_STATE_OFS = 4'hC;
	// Field positions in hardware_control_register
	localparam int AUTO_UP_EN_BIT = 0;
	localparam int LAG_SEL_BIT = 1;
	localparam int PIN_MOD_EN_BIT = 2;
	localparam int BOOST_EN_BIT = 3;
	// Field position in wake_status_register_one
	localparam int AUTO_UP_FLAG_BIT = 0;
	// Reset values
	localparam logic [31:0] HARDWARE_CONTROL_REGISTER_RST = 32'h0000_0001;
	localparam logic [2:0] MODE_RST = 3'h0;
	// Timing
	localparam int CLK_HZ = 100_000_000;
	localparam int LAG_LONG_US = 1000;
	localparam int LAG_SHORT_US = 100;
	localparam int LAG_LONG_CYC = LAG_LONG_US * (CLK_HZ / 1_000_000);
	localparam int LAG_SHORT_CYC = LAG_SHORT_US * (CLK_HZ / 1_000_000);
	localparam int BUCK_FREQ_KHZ = 450;
	localparam int BUCK_DIV_CYC = CLK_HZ / (BUCK_FREQ_KHZ * 1000);
	localparam int CNT_W = 20;
	// Operating modes as written in the mode control register
	typedef enum logic [2:0] {
		OP_NORMAL = 3'h0,
		OP_STOP = 3'h1,
		OP_SLEEP = 3'h2,
		OP_FAILSAFE = 3'h3,
		OP_RESTART = 3'h4
	} op_mode_t;
endpackage

/* File: pkg/modctl_if.sv */
// Carries the lag timer request and its expiry between top and timer
interface modctl_if;
	logic start;
	logic long_sel;
	logic busy;
	logic done;
	modport master (output start, output long_sel, input busy, input done);
	modport timer (input start, input long_sel, output busy, output done);
endinterface

/* File: rtl/lag_timer.sv */
module lag_timer (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	modctl_if.timer tmr
);
	import modctl_pkg::*;
	logic [CNT_W-1:0] cnt_r, cnt_nxt;
	logic done_r, done_nxt;

	// Restart on every request so a repeated PWM-to-PFM change gets the full lag
	always_comb begin
		cnt_nxt = cnt_r;
		done_nxt = 1'b0;
		if (tmr.start) begin
			cnt_nxt = tmr.long_sel ? CNT_W'(LAG_LONG_CYC) : CNT_W'(LAG_SHORT_CYC);
		end else if (cnt_r != '0) begin
			cnt_nxt = cnt_r - CNT_W'(1);
			done_nxt = (cnt_r == CNT_W'(1));
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_r <= '0;
			done_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			done_r <= done_nxt;
		end
	end

	assign tmr.busy = (cnt_r != '0);
	assign tmr.done = done_r;
endmodule

/* File: rtl/pwm_tick.sv */
module pwm_tick (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic run_i,
	output logic tick_o
);
	import modctl_pkg::*;
	logic [7:0] div_r, div_nxt;
	logic tick_r, tick_nxt;

	// Fixed-rate switching enable; held in reset while not running
	always_comb begin
		div_nxt = div_r;
		tick_nxt = 1'b0;
		if (!run_i) begin
			div_nxt = '0;
		end else if (div_r == 8'(BUCK_DIV_CYC - 1)) begin
			div_nxt = '0;
			tick_nxt = 1'b1;
		end else begin
			div_nxt = div_r + 8'h01;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			div_r <= '0;
			tick_r <= 1'b0;
		end else begin
			div_r <= div_nxt;
			tick_r <= tick_nxt;
		end
	end

	assign tick_o = tick_r;
endmodule

/* File: verif/modctl_chk.sv */
module modctl_chk
	import modctl_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic [3:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic avs_waitrequest_o,
	input wire logic boost_peak_oc_i,
	input wire logic buck_above_rst_thr_i,
	input wire logic buck_en_o,
	input wire logic buck_pwm_o,
	input wire logic buck_tick_o,
	input wire logic boost_on_o,
	input wire logic boost_duty_down_o,
	input wire logic int_event_o,
	input wire logic reset_output_pin_n_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	logic [7:0] gap_r;
	logic ok_r;
	logic [13:0] lag_r;
	logic stop_wr;
	// Taken Stop write; a repeated Stop restarts the lag too
	assign stop_wr = avs_write_i && avs_waitrequest_o && avs_address_i == MODE_CTRL_OFS
		&& avs_writedata_i[2:0] == 3'h1;
	// Gap trusted only inside one unbroken PWM run; lag count saturates so it never wraps
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			gap_r <= 8'h00;
			ok_r <= 1'b0;
			lag_r <= 14'h3FFF;
		end else begin
			gap_r <= buck_tick_o ? 8'h00 : gap_r + 8'h01;
			ok_r <= (ok_r || buck_tick_o) && buck_pwm_o;
			lag_r <= stop_wr ? 14'h0000 : lag_r + {13'h0, lag_r != 14'h3FFF};
		end
	end
	a_duty_cut: assert property (
		boost_peak_oc_i ##1 boost_on_o |-> boost_duty_down_o) else $error("duty not cut");
	a_tick_gap: assert property (
		ok_r && buck_pwm_o |-> gap_r < 8'(BUCK_DIV_CYC)
		&& (!buck_tick_o || gap_r == 8'(BUCK_DIV_CYC - 1))) else $error("tick gap");
	a_stop_pfm: assert property (
		stop_wr && buck_en_o && reset_output_pin_n_o |=> !buck_pwm_o) else $error("no pfm");
	a_lag_hold: assert property (
		int_event_o |-> lag_r >= 14'(LAG_SHORT_CYC - 2)) else $error("upshift in lag");
	a_int_pulse: assert property (
		int_event_o |=> !int_event_o) else $error("int too long");
	a_off_both: assert property (
		!buck_en_o |-> !boost_on_o && !buck_pwm_o) else $error("boost on while off");
	a_rst_free: assert property (
		buck_en_o && buck_above_rst_thr_i && !reset_output_pin_n_o |=> reset_output_pin_n_o)
		else $error("reset held");
	a_bus_answer: assert property (
		(avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
		else $error("late answer");
endmodule

bind buck_boost_modulation_control modctl_chk chk_u (.*);

/* File: verif/mcu_wake_model.sv */
module mcu_wake_model (
	input wire logic core_clk_i,
	input wire logic want_pwm_i,
	output logic wake_pin_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// Pin moves just after an edge, like a port pin of the controller
	initial wake_pin_o = 1'b0;
	always @(posedge core_clk_i) begin
		wake_pin_o <= want_pwm_i;
	end
endmodule

/* File: verif/buck_boost_modulation_control_test.sv */
module buck_boost_modulation_control_test
	import modctl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk_i = 1'b0, rst_n_i = 1'b0, avs_read_i = 1'b0, avs_write_i = 1'b0;
	logic [3:0] avs_address_i = 4'h0, avs_byteenable_i = 4'hF;
	logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, rd;
	logic [1:0] avs_response_o, rsp;
	logic bus_wake_i = 1'b0, load_over_thr_i = 1'b0, supply_below_thr_i = 1'b0;
	logic supply_above_hys_i = 1'b0, boost_peak_oc_i = 1'b0, buck_above_rst_thr_i = 1'b0;
	logic want_pwm = 1'b0, avs_waitrequest_o, wake_pin_i, buck_en_o, buck_pwm_o;
	logic buck_tick_o, boost_on_o, boost_duty_down_o, int_event_o, reset_output_pin_n_o;
	int num_errors = 0, tests_run = 0, n;
	// 100 MHz clock
	always #5 core_clk_i = ~core_clk_i;
	buck_boost_modulation_control dut (.*);
	mcu_wake_model mcu (.core_clk_i, .want_pwm_i(want_pwm), .wake_pin_o(wake_pin_i));
	// Compare and count
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %s expected %0h seen %0h", nm, exp, got);
		end
	endtask
	task automatic settle(input int c);
		repeat (c) @(posedge core_clk_i);
	endtask
	// Whole PWM periods in a window of cycles
	function automatic int exp_ticks(input int cyc);
		exp_ticks = cyc / BUCK_DIV_CYC;
	endfunction
	// One transfer; request held until waitrequest is seen low, then released
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge core_clk_i);
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_write_i <= w;
		avs_read_i <= !w;
		do begin
			@(posedge core_clk_i);
			k++;
		end while (avs_waitrequest_o !== 1'b0 && k < 20);
		rd = avs_readdata_o;
		rsp = avs_response_o;
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
		if (k >= 20) chk("bus answer", 0, 1);
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// Run takes about 35k cycles; 50k means a hang
	initial begin
		#500us;
		num_errors++;
		complete_run();
	end
	initial begin
		void'($urandom(32'h1CE03B4C));
		repeat (6) @(posedge core_clk_i);
		chk("buck_en", 1, buck_en_o);
		chk("rst out", 0, reset_output_pin_n_o);
		rst_n_i <= 1'b1;
		settle(3);
		buck_above_rst_thr_i <= 1'b1;
		settle(3);
		chk("rst free", 1, reset_output_pin_n_o);
		bus(0, HARDWARE_CONTROL_REGISTER_OFS, 0);
		chk("hw reset", HARDWARE_CONTROL_REGISTER_RST, rd);
		bus(0, MODE_CTRL_OFS, 0);
		chk("mode", OP_NORMAL, rd);
		bus(0, 4'h6, 0);
		chk("resp", 2'h2, rsp);
		n = 0;
		repeat (2220) begin
			@(posedge core_clk_i);
			n += int'(buck_tick_o);
		end
		chk("ticks", exp_ticks(2220), n);
		// Random load and pin noise must not move Normal off PWM
		repeat (200) begin
			@(posedge core_clk_i);
			load_over_thr_i <= 1'($urandom);
			want_pwm <= 1'($urandom);
			chk("pwm", 1, buck_pwm_o);
		end
		$display("normal test done");
		// Auto upshift only after the short lag; a fresh Stop returns to PFM
		load_over_thr_i <= 1'b1;
		want_pwm <= 1'b0;
		supply_below_thr_i <= 1'b1;
		bus(1, HARDWARE_CONTROL_REGISTER_OFS, 32'h9);
		bus(1, MODE_CTRL_OFS, OP_STOP);
		chk("pfm", 0, buck_pwm_o);
		chk("boost", 1, boost_on_o);
		settle(9000);
		chk("lag", 0, buck_pwm_o);
		n = 0;
		while (int_event_o !== 1'b1 && n < 2000) begin
			@(posedge core_clk_i);
			n++;
		end
		chk("int", 1, n < 2000);
		settle(2);
		chk("upshift", 1, buck_pwm_o);
		load_over_thr_i <= 1'b0;
		bus(1, MODE_CTRL_OFS, OP_STOP);
		chk("back pfm", 0, buck_pwm_o);
		bus(0, WAKE_STAT_OFS, 0);
		chk("flag", 1, rd[AUTO_UP_FLAG_BIT]);
		bus(1, WAKE_STAT_OFS, 1);
		bus(0, WAKE_STAT_OFS, 0);
		chk("flag clr", 0, rd[AUTO_UP_FLAG_BIT]);
		// Pin mode with auto upshift off: load ignored, the pin decides
		load_over_thr_i <= 1'b1;
		bus(1, HARDWARE_CONTROL_REGISTER_OFS, 32'hC);
		settle(10200);
		chk("no auto", 0, buck_pwm_o);
		want_pwm <= 1'b1;
		settle(4);
		chk("pin pwm", 1, buck_pwm_o);
		want_pwm <= 1'b0;
		settle(10100);
		chk("pin pfm", 0, buck_pwm_o);
		bus(1, HARDWARE_CONTROL_REGISTER_OFS, 32'h8);
		want_pwm <= 1'b1;
		settle(20);
		chk("pin off", 0, buck_pwm_o);
		bus(1, MODE_CTRL_OFS, OP_NORMAL);
		chk("normal", 1, buck_pwm_o);
		chk("boost kept", 1, boost_on_o);
		// Boost drops above hysteresis; overcurrent cuts duty once back on
		supply_below_thr_i <= 1'b0;
		supply_above_hys_i <= 1'b1;
		settle(4);
		chk("boost off", 0, boost_on_o);
		supply_above_hys_i <= 1'b0;
		supply_below_thr_i <= 1'b1;
		settle(4);
		boost_peak_oc_i <= 1'b1;
		settle(3);
		chk("duty", 1, boost_duty_down_o);
		boost_peak_oc_i <= 1'b0;
		want_pwm <= 1'b0;
		$display("stop test done");
		// Sleep turns both off and ignores mode writes; a wake goes via Restart
		bus(1, MODE_CTRL_OFS, OP_SLEEP);
		buck_above_rst_thr_i <= 1'b0;
		settle(2);
		chk("sleep buck", 0, buck_en_o);
		chk("sleep boost", 0, boost_on_o);
		bus(1, MODE_CTRL_OFS, OP_NORMAL);
		bus(0, MODE_CTRL_OFS, 0);
		chk("sleep kept", OP_SLEEP, rd);
		want_pwm <= 1'b1;
		settle(4);
		chk("restart", 1, buck_en_o);
		chk("rst low", 0, reset_output_pin_n_o);
		chk("boost back", 1, boost_on_o);
		buck_above_rst_thr_i <= 1'b1;
		settle(4);
		bus(0, MODE_CTRL_OFS, 0);
		chk("mode up", OP_NORMAL, rd);
		want_pwm <= 1'b0;
		bus(1, MODE_CTRL_OFS, OP_FAILSAFE);
		settle(2);
		chk("fs buck", 0, buck_en_o);
		bus_wake_i <= 1'b1;
		settle(4);
		chk("fs wake", 1, buck_en_o);
		bus_wake_i <= 1'b0;
		$display("sleep test done");
		complete_run();
	end
endmodule
